// [design/ptap_top.sv]
/*
 * Test access port of an in-system programmable configuration PROM:
 * controller, instruction and data registers, boundary chain, identity
 * and user code, read protection and the configuration request pulse.
 * Assumes the test clock tck as its own domain, mclk at 50 MHz, and a
 * flash engine on mclk that reports mode, writes and erase completion.
 */
`timescale 1ns/1ps
`include "ptap_params.svh"

module ptap_top #(
	parameter logic [3:0]  ID_VERSION = 4'h1,   // Arbitrary value
	parameter logic [7:0]  ID_FAMILY  = 8'h3c,  // Arbitrary value
	parameter logic [7:0]  ID_PRODUCT = 8'h5a,  // Arbitrary value
	parameter logic [10:0] ID_COMPANY = 11'h1a5 // Arbitrary value
) (
	input  wire logic                         mclk,
	input  wire logic                         rstn,
	input  wire logic                         tck,
	input  wire logic                         tms,
	input  wire logic                         tdi,
	output logic                              tdo,
	output logic                              tdo_oe,
	input  wire logic                         in_system_prog,
	input  wire logic                         isp_reset_req,
	input  wire logic                         nv_read_protect,
	input  wire logic [`PTAP_DR_W-1:0]        nv_user_code,
	input  wire logic                         prog_read_protect,
	input  wire logic                         full_erase_done,
	input  wire logic                         user_code_wr,
	input  wire logic [`PTAP_DR_W-1:0]        user_code_data,
	input  wire logic [`PTAP_N_CORE_OUT-1:0]  core_out,
	input  wire logic [`PTAP_N_CORE_OUT-1:0]  core_oe,
	input  wire logic [`PTAP_N_IN-1:0]        pin_in,
	output logic      [`PTAP_N_IN-1:0]        core_in,
	output logic                              fpga_config_request_n_out,
	output logic                              fpga_config_request_n_oe,
	output logic                              oe_reset_n_out,
	output logic                              oe_reset_n_oe,
	output logic      [`PTAP_N_CORE_OUT-1:0]  pin_out,
	output logic      [`PTAP_N_CORE_OUT-1:0]  pin_oe,
	output logic                              flash_read_permit,
	output logic                              flash_program_permit
);
	import ptap_pkg::*;

	localparam int NO = `PTAP_N_OUT;
	localparam int NI = `PTAP_N_IN;
	localparam int BW = `PTAP_BSR_W;

	// Test clock domain
	ptap_state_type          state;
	ptap_state_type          next_state;
	ptap_dr_type             dr_sel;
	logic [`PTAP_IR_W-1:0]   ir_shift;
	logic [`PTAP_IR_W-1:0]   instr_reg;
	logic [`PTAP_IR_W-1:0]   ir_cap;
	logic [`PTAP_DR_W-1:0]   dr_shift;
	logic [`PTAP_DR_W-1:0]   id_value;
	logic [`PTAP_DR_W-1:0]   user_code_t;
	logic                    bypass_reg;
	logic [BW-1:0]           bsr;
	logic [BW-1:0]           bsr_cap;
	logic [BW-1:0]           bsr_upd;
	logic [2:0]              mode_t;
	logic                    cfg_tgl_t;
	logic [1:0]              isp_sy;
	logic [1:0]              sec_sy;
	logic [2:0]              utg_sy;
	logic [NI-1:0]           pin_sy1;
	logic [NI-1:0]           pin_t;
	logic [2*NO-1:0]         drv_sy1;
	logic [2*NO-1:0]         drv_t;
	logic                    dr_tdo;

	// Main clock domain
	logic [2:0]              mode_sy1;
	logic [2:0]              mode_m;
	logic [BW-1:0]           upd_sy1;
	logic [BW-1:0]           upd_m;
	logic [2:0]              cfg_sy;
	logic [NI-1:0]           pin_msy1;
	logic [NI-1:0]           pin_m;
	logic [`PTAP_CF_CNT_W-1:0] cf_cnt;
	logic                    loaded;
	logic                    read_protect;
	logic [`PTAP_DR_W-1:0]   user_code;
	logic                    user_tgl;
	logic [NO-1:0]           out_q;
	logic [NO-1:0]           oe_q;
	logic [NO-1:0]           func_out;
	logic [NO-1:0]           func_oe;
	logic [NO-1:0]           next_out;
	logic [NO-1:0]           next_oe;
	logic [NI-1:0]           next_core_in;

	// Controller
	always_comb begin
		next_state = state;
		unique case (state)
			st_reset:  next_state = tms ? st_reset  : st_idle;
			st_idle:   next_state = tms ? st_sel_dr : st_idle;
			st_sel_dr: next_state = tms ? st_sel_ir : st_cap_dr;
			st_cap_dr: next_state = tms ? st_ex1_dr : st_sh_dr;
			st_sh_dr:  next_state = tms ? st_ex1_dr : st_sh_dr;
			st_ex1_dr: next_state = tms ? st_up_dr  : st_pa_dr;
			st_pa_dr:  next_state = tms ? st_ex2_dr : st_pa_dr;
			st_ex2_dr: next_state = tms ? st_up_dr  : st_sh_dr;
			st_up_dr:  next_state = tms ? st_sel_dr : st_idle;
			st_sel_ir: next_state = tms ? st_reset  : st_cap_ir;
			st_cap_ir: next_state = tms ? st_ex1_ir : st_sh_ir;
			st_sh_ir:  next_state = tms ? st_ex1_ir : st_sh_ir;
			st_ex1_ir: next_state = tms ? st_up_ir  : st_pa_ir;
			st_pa_ir:  next_state = tms ? st_ex2_ir : st_pa_ir;
			st_ex2_ir: next_state = tms ? st_up_ir  : st_sh_ir;
			st_up_ir:  next_state = tms ? st_sel_dr : st_idle;
			default:   next_state = st_reset;
		endcase
	end

	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			state <= st_reset;
		end else begin
			state <= next_state;
		end
	end

	// Status levels and pin states brought into the test clock
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			isp_sy  <= 2'h0;
			sec_sy  <= 2'h0;
			utg_sy  <= 3'h0;
			pin_sy1 <= '0;
			pin_t   <= '0;
			drv_sy1 <= '0;
			drv_t   <= '0;
		end else begin
			isp_sy  <= {isp_sy[0], in_system_prog};
			sec_sy  <= {sec_sy[0], read_protect};
			utg_sy  <= {utg_sy[1:0], user_tgl};
			pin_sy1 <= pin_in;
			pin_t   <= pin_sy1;
			drv_sy1 <= {oe_q, out_q};
			drv_t   <= drv_sy1;
		end
	end

	// User code copied once its toggle has settled
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			user_code_t <= `PTAP_USER_CODE_REGISTER_BLANK;
		end else if (utg_sy[2] != utg_sy[1]) begin
			user_code_t <= user_code;
		end
	end

	// Capture pattern
	always_comb begin
		ir_cap = `PTAP_IR_CAP_FIXED;
		ir_cap[`PTAP_CAP_ISP_BIT] = isp_sy[1];
		ir_cap[`PTAP_CAP_SEC_BIT] = sec_sy[1];
	end

	// Instruction register
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			ir_shift  <= `PTAP_IR_CAP_FIXED;
			instr_reg <= `PTAP_IR_RESET;
			cfg_tgl_t <= 1'h0;
		end else begin
			unique case (state)
				st_reset: instr_reg <= `PTAP_IR_RESET;
				st_cap_ir: ir_shift <= ir_cap;
				st_sh_ir: ir_shift <= {tdi, ir_shift[`PTAP_IR_W-1:1]};
				st_up_ir: begin
					instr_reg <= ir_shift;
					if (ir_shift == `PTAP_OP_CONFIG) begin
						cfg_tgl_t <= ~cfg_tgl_t;
					end
				end
				default: ;
			endcase
		end
	end

	// Data register selection
	always_comb begin
		unique case (instr_reg)
			`PTAP_OP_EXTEST:   dr_sel = dr_bsr;
			`PTAP_OP_SAMPLE:   dr_sel = dr_bsr;
			`PTAP_OP_IDENTIFICATION_REGISTER:   dr_sel = dr_ident;
			`PTAP_OP_USER_CODE_REGISTER: dr_sel = dr_user;
			`PTAP_OP_CLAMP:    dr_sel = dr_bypass;
			default:           dr_sel = dr_bypass;
		endcase
	end

	assign id_value = {ID_VERSION, ID_FAMILY, ID_PRODUCT, ID_COMPANY,
		`PTAP_ID_LSB};

	// Boundary capture: enable cell at 2k, data cell at 2k+1, inputs above
	genvar k;
	generate
		for (k = 0; k < NO; k++) begin : g_out_cells
			assign bsr_cap[2*k]   = drv_t[NO+k];
			assign bsr_cap[2*k+1] = drv_t[k];
		end
		for (k = 0; k < NI; k++) begin : g_in_cells
			assign bsr_cap[2*NO+k] = pin_t[k];
		end
	endgenerate

	// Data registers
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			dr_shift   <= '0;
			bypass_reg <= 1'h0;
			bsr        <= '0;
			bsr_upd    <= '0;
		end else begin
			unique case (state)
				st_cap_dr: begin
					bypass_reg <= 1'h0;
					if (dr_sel == dr_bsr) begin
						bsr <= bsr_cap;
					end
					if (dr_sel == dr_user) begin
						dr_shift <= user_code_t;
					end else begin
						dr_shift <= id_value;
					end
				end
				st_sh_dr: begin
					bypass_reg <= tdi;
					if (dr_sel == dr_bsr) begin
						bsr <= {tdi, bsr[BW-1:1]};
					end
					dr_shift <= {tdi, dr_shift[`PTAP_DR_W-1:1]};
				end
				st_up_dr: begin
					if (dr_sel == dr_bsr) begin
						bsr_upd <= bsr;
					end
				end
				default: ;
			endcase
		end
	end

	// Registered pin modes: extest, clamp, highz
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			mode_t <= 3'h0;
		end else begin
			mode_t[0] <= (instr_reg == `PTAP_OP_EXTEST);
			mode_t[1] <= (instr_reg == `PTAP_OP_CLAMP);
			mode_t[2] <= (instr_reg == `PTAP_OP_HIGHZ);
		end
	end

	always_comb begin
		unique case (dr_sel)
			dr_bsr:    dr_tdo = bsr[0];
			dr_ident:  dr_tdo = dr_shift[0];
			dr_user:   dr_tdo = dr_shift[0];
			dr_bypass: dr_tdo = bypass_reg;
			default:   dr_tdo = bypass_reg;
		endcase
	end

	// Serial output changes on the falling edge
	always_ff @(negedge tck or negedge rstn) begin
		if (!rstn) begin
			tdo    <= 1'h0;
			tdo_oe <= 1'h0;
		end else begin
			tdo_oe <= (state == st_sh_ir) || (state == st_sh_dr);
			if (state == st_sh_ir) begin
				tdo <= ir_shift[0];
			end else if (state == st_sh_dr) begin
				tdo <= dr_tdo;
			end
		end
	end

	// Main clock: crossings from the test clock and of the pin inputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_sy1 <= 3'h0;
			mode_m   <= 3'h0;
			upd_sy1  <= '0;
			upd_m    <= '0;
			cfg_sy   <= 3'h0;
			pin_msy1 <= '0;
			pin_m    <= '0;
		end else begin
			mode_sy1 <= mode_t;
			mode_m   <= mode_sy1;
			upd_sy1  <= bsr_upd;
			upd_m    <= upd_sy1;
			cfg_sy   <= {cfg_sy[1:0], cfg_tgl_t};
			pin_msy1 <= pin_in;
			pin_m    <= pin_msy1;
		end
	end

	// Configuration request pulse
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cf_cnt <= '0;
		end else if (cfg_sy[2] != cfg_sy[1]) begin
			cf_cnt <= `PTAP_CF_CNT_W'(`PTAP_CF_CYC);
		end else if (cf_cnt != '0) begin
			cf_cnt <= cf_cnt - `PTAP_CF_CNT_W'(1);
		end
	end

	// Nonvolatile state loaded after reset, then kept by programming
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			loaded       <= 1'h0;
			read_protect <= 1'h0;
			user_code    <= `PTAP_USER_CODE_REGISTER_BLANK;
			user_tgl     <= 1'h0;
		end else begin
			loaded <= 1'h1;
			if (!loaded) begin
				read_protect <= nv_read_protect;
				user_code    <= nv_user_code;
				user_tgl     <= ~user_tgl;
			end else begin
				if (prog_read_protect) begin
					read_protect <= 1'h1;
				end else if (full_erase_done) begin
					read_protect <= 1'h0;
				end
				if (user_code_wr) begin
					user_code <= user_code_data;
					user_tgl  <= ~user_tgl;
				end else if (full_erase_done) begin
					user_code <= `PTAP_USER_CODE_REGISTER_BLANK;
					user_tgl  <= ~user_tgl;
				end
			end
		end
	end

	// Flash access permits
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flash_read_permit    <= 1'h0;
			flash_program_permit <= 1'h0;
		end else begin
			flash_read_permit    <= loaded && !read_protect;
			flash_program_permit <= loaded && !read_protect;
		end
	end

	// Functional pin values
	always_comb begin
		func_out = '0;
		func_oe  = '0;
		func_oe[`PTAP_PIN_CF]    = (cf_cnt != '0);
		func_oe[`PTAP_PIN_OERST] = isp_reset_req;
		for (int i = 0; i < `PTAP_N_CORE_OUT; i++) begin
			func_out[i+2] = core_out[i];
			func_oe[i+2]  = core_oe[i];
		end
	end

	// Pin selection between function, boundary and float
	always_comb begin
		next_out = func_out;
		next_oe  = func_oe;
		if (mode_m[2]) begin
			next_oe = '0;
		end else if (mode_m[0] || mode_m[1]) begin
			for (int i = 0; i < NO; i++) begin
				next_out[i] = upd_m[2*i+1];
				next_oe[i]  = upd_m[2*i];
			end
		end else if (in_system_prog) begin
			next_oe = '0;
		end
		next_core_in = mode_m[0] ? upd_m[BW-1:2*NO] : pin_m;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			out_q   <= '0;
			oe_q    <= '0;
			core_in <= '0;
		end else begin
			out_q   <= next_out;
			oe_q    <= next_oe;
			core_in <= next_core_in;
		end
	end

	assign fpga_config_request_n_out = out_q[`PTAP_PIN_CF];
	assign fpga_config_request_n_oe  = oe_q[`PTAP_PIN_CF];
	assign oe_reset_n_out            = out_q[`PTAP_PIN_OERST];
	assign oe_reset_n_oe             = oe_q[`PTAP_PIN_OERST];
	assign pin_out                   = out_q[NO-1:2];
	assign pin_oe                    = oe_q[NO-1:2];

endmodule

// [design/ptap_params.svh]
/*
 * Constants of the configuration PROM test access port: instruction codes,
 * capture pattern layout, boundary chain size and pulse timing.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef PTAP_PARAMS_SVH
`define PTAP_PARAMS_SVH

`define PTAP_IR_W           8
`define PTAP_OP_EXTEST      8'h00
`define PTAP_OP_SAMPLE      8'h01
`define PTAP_OP_CLAMP       8'hfa
`define PTAP_OP_HIGHZ       8'hfc
`define PTAP_OP_USER_CODE_REGISTER    8'hfd
`define PTAP_OP_IDENTIFICATION_REGISTER      8'hfe
`define PTAP_OP_BYPASS      8'hff
`define PTAP_OP_CONFIG      8'hee
`define PTAP_IR_RESET       8'hfe

`define PTAP_IR_CAP_FIXED   8'h01
`define PTAP_CAP_ISP_BIT    4
`define PTAP_CAP_SEC_BIT    3

`define PTAP_DR_W           32
`define PTAP_ID_LSB         1'h1
`define PTAP_USER_CODE_REGISTER_BLANK 32'hffffffff

`define PTAP_N_OUT          4
`define PTAP_N_CORE_OUT     2
`define PTAP_N_IN           4
`define PTAP_BSR_W          12
`define PTAP_PIN_CF         0
`define PTAP_PIN_OERST      1

`define PTAP_MCLK_NS        20
`define PTAP_CF_MIN_NS      300
`define PTAP_CF_MAX_NS      500
`define PTAP_CF_MIN_CYC     ((`PTAP_CF_MIN_NS + `PTAP_MCLK_NS - 1) / `PTAP_MCLK_NS)
`define PTAP_CF_MAX_CYC     (`PTAP_CF_MAX_NS / `PTAP_MCLK_NS)
`define PTAP_CF_CYC         ((`PTAP_CF_MIN_CYC + `PTAP_CF_MAX_CYC) / 2)
`define PTAP_CF_CNT_W       5

`endif

// [design/ptap_pkg.sv]
/*
 * Types of the configuration PROM test access port: controller states and
 * data register selection.
 * Assumes ptap_params.svh is on the include path.
 */
`include "ptap_params.svh"

package ptap_pkg;

	typedef enum logic [15:0] {
		st_reset  = 16'h0001,
		st_idle   = 16'h0002,
		st_sel_dr = 16'h0004,
		st_cap_dr = 16'h0008,
		st_sh_dr  = 16'h0010,
		st_ex1_dr = 16'h0020,
		st_pa_dr  = 16'h0040,
		st_ex2_dr = 16'h0080,
		st_up_dr  = 16'h0100,
		st_sel_ir = 16'h0200,
		st_cap_ir = 16'h0400,
		st_sh_ir  = 16'h0800,
		st_ex1_ir = 16'h1000,
		st_pa_ir  = 16'h2000,
		st_ex2_ir = 16'h4000,
		st_up_ir  = 16'h8000
	} ptap_state_type;

	typedef enum logic [3:0] {
		dr_bypass = 4'h1,
		dr_bsr    = 4'h2,
		dr_ident  = 4'h4,
		dr_user   = 4'h8
	} ptap_dr_type;

endpackage

// [tb/ptap_master.sv]
/*
 * External test port master: drives tck, tms and tdi, samples tdo.
 * Assumes the device updates tdo on falling tck; tck idles low.
 */
`timescale 1ns/1ps

module ptap_master (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One 80 ns period, tdo taken at the rising edge
	task tick(input logic t, input logic v, output logic q);
		tms = t;
		tdi = v;
		#40 tck = 1'b1;
		q = tdo;
		#40 tck = 1'b0;
	endtask

	// Five ones reset the controller, then idle
	task tap_reset();
		logic q;
		#7;
		repeat (5) tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
	endtask

	// Idle to idle scan, lsb first, idle clocks let modes cross
	task scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = 32'h0;
		#7;
		tick(1'b1, 1'b1, q);
		if (ir)
			tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
		tick(1'b0, 1'b1, q);
		for (int k = 0; k < n; k++) begin
			tick(k == n - 1, din[k], q);
			dout[k] = q;
		end
		tick(1'b1, 1'b1, q);
		repeat (4) tick(1'b0, 1'b1, q);
	endtask
endmodule

// [tb/ptap_props.sv]
/*
 * Checks on shift enable, open-drain pins and read protection.
 * Assumes mclk at 50 MHz and tck as an unrelated domain.
 */
`timescale 1ns/1ps

module ptap_props (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo_oe,
	input wire logic isp_reset_req,
	input wire logic prog_read_protect,
	input wire logic full_erase_done,
	input wire logic fpga_config_request_n_out,
	input wire logic fpga_config_request_n_oe,
	input wire logic oe_reset_n_out,
	input wire logic oe_reset_n_oe,
	input wire logic flash_read_permit,
	input wire logic flash_program_permit
);
	logic [5:0] cfg_cnt;

	// Cycles of the current low pulse
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			cfg_cnt <= 6'h00;
		else if (fpga_config_request_n_oe)
			cfg_cnt <= cfg_cnt + 6'h01;
		else
			cfg_cnt <= 6'h00;
	end

	a_cfg_open_drain: assert property (
		@(posedge mclk) disable iff (!rstn) !fpga_config_request_n_out)
		else $error("config request driven high");
	a_cfg_pulse_len: assert property (
		@(posedge mclk) disable iff (!rstn)
		$fell(fpga_config_request_n_oe) |-> cfg_cnt >= 15 && cfg_cnt <= 25)
		else $error("config pulse length wrong");
	a_shift_exit: assert property (
		@(posedge tck) disable iff (!rstn) tdo_oe && tms |=> !tdo_oe)
		else $error("tdo enable after shift exit");
	a_shift_hold: assert property (
		@(posedge tck) disable iff (!rstn) tdo_oe && !tms |=> tdo_oe)
		else $error("tdo enable lost in shift");
	a_permit_pair: assert property (
		@(posedge mclk) disable iff (!rstn)
		flash_program_permit == flash_read_permit)
		else $error("program and read permits differ");
	a_protect_set: assert property (
		@(posedge mclk) disable iff (!rstn)
		prog_read_protect |-> ##[2:3] !flash_read_permit)
		else $error("read allowed after protect");
	a_erase_clear: assert property (
		@(posedge mclk) disable iff (!rstn)
		full_erase_done && !prog_read_protect |-> ##[2:3] flash_read_permit)
		else $error("erase left read blocked");
	a_oerst_low: assert property (
		@(posedge mclk) disable iff (!rstn) $rose(isp_reset_req)
		|-> ##[1:4] (oe_reset_n_oe && !oe_reset_n_out))
		else $error("oe reset not driven low");
endmodule

bind ptap_top ptap_props props_u (.mclk(mclk), .rstn(rstn), .tck(tck),
	.tms(tms), .tdo_oe(tdo_oe), .isp_reset_req(isp_reset_req),
	.prog_read_protect(prog_read_protect),
	.full_erase_done(full_erase_done),
	.fpga_config_request_n_out(fpga_config_request_n_out),
	.fpga_config_request_n_oe(fpga_config_request_n_oe),
	.oe_reset_n_out(oe_reset_n_out), .oe_reset_n_oe(oe_reset_n_oe),
	.flash_read_permit(flash_read_permit),
	.flash_program_permit(flash_program_permit));

// [tb/ptap_top_test.sv]
/*
 * Bench of ptap_top: scans through ptap_master, mclk inputs by hand.
 * Assumes the checker binds itself from its own file.
 */
`timescale 1ns/1ps

module ptap_top_test;
	logic        mclk = 1'b0, rstn = 1'b0, tck, tms, tdi, tdo, tdo_oe;
	logic        in_system_prog = 1'b0, isp_reset_req = 1'b0;
	logic        prog_read_protect = 1'b0, full_erase_done = 1'b0;
	logic        user_code_wr = 1'b0, cfg_out, cfg_oe, oer_out, oer_oe;
	logic        rd_ok, pg_ok;
	logic [31:0] user_code_data = 32'h0, d;
	logic [1:0]  pin_out, pin_oe;
	logic [3:0]  core_in;
	logic [7:0]  c;
	logic [7:0]  ops [3] = '{8'hff, 8'h55, 8'hef};
	int          miscompares = 0, num_checks = 0, i, n;

	ptap_top #(.ID_VERSION(4'h2), .ID_FAMILY(8'h71), // Arbitrary values
		.ID_PRODUCT(8'h4b), .ID_COMPANY(11'h2c3)) dut_u (
		.mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .in_system_prog(in_system_prog),
		.isp_reset_req(isp_reset_req), .nv_read_protect(1'b0),
		.nv_user_code(32'hffffffff), .prog_read_protect(prog_read_protect),
		.full_erase_done(full_erase_done), .user_code_wr(user_code_wr),
		.user_code_data(user_code_data), .core_out(2'b10),
		.core_oe(2'b11), .pin_in(4'h5), .core_in(core_in),
		.fpga_config_request_n_out(cfg_out),
		.fpga_config_request_n_oe(cfg_oe), .oe_reset_n_out(oer_out),
		.oe_reset_n_oe(oer_oe), .pin_out(pin_out), .pin_oe(pin_oe),
		.flash_read_permit(rd_ok), .flash_program_permit(pg_ok));
	ptap_master m_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	always #10 mclk = ~mclk;

	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			miscompares++;
		end
	endtask

	task tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task tmo(input int k);
		if (k >= 300) begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	task ir(input logic [7:0] op);
		m_u.scan(1'b1, 8, {24'h0, op}, d);
		c = d[7:0];
	endtask

	task dr(input int k, input logic [31:0] din);
		m_u.scan(1'b0, k, din, d);
	endtask

	initial begin
		repeat (5) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		chk("permits", 32'h3, 32'({rd_ok, pg_ok}));
		m_u.tap_reset();
		ir(8'hfe);
		chk("ir_capture", 32'h01, 32'(c));
		dr(32, 32'h0);
		chk("identification_register", {4'h2, 8'h71, 8'h4b, 11'h2c3, 1'b1}, d);
		ir(8'hfd);
		dr(32, 32'h0);
		chk("user_code_register", 32'hffffffff, d);
		@(negedge mclk) user_code_data = 32'h0badcafe;
		user_code_wr = 1'b1;
		@(negedge mclk) user_code_wr = 1'b0;
		ir(8'hfd);
		dr(32, 32'h0);
		chk("user_code_register", 32'h0badcafe, d);
		foreach (ops[k]) begin
			ir(ops[k]);
			dr(2, 32'h3);
			chk("bypass", 32'h2, d);
		end
		fork
			ir(8'hee);
			begin
				for (i = 0; i < 300 && cfg_oe !== 1'b1; i++) @(negedge mclk);
				for (n = 0; n < 40 && cfg_oe === 1'b1; n++) @(negedge mclk);
			end
		join
		tmo(i);
		chk("cfg_len_ok", 32'h1, 32'(n >= 15 && n <= 25));
		chk("cfg_pins", 32'h0, 32'({cfg_out, cfg_oe}));
		@(negedge mclk) isp_reset_req = 1'b1;
		for (i = 0; i < 300 && oer_oe !== 1'b1; i++) @(negedge mclk);
		tmo(i);
		chk("oe_reset_out", 32'h0, 32'(oer_out));
		isp_reset_req = 1'b0;
		ir(8'hfc);
		for (i = 0; i < 300 && pin_oe !== 2'b00; i++) @(negedge mclk);
		tmo(i);
		chk("highz_oe", 32'h0, 32'({cfg_oe, oer_oe, pin_oe}));
		ir(8'h01);
		for (i = 0; i < 300 && pin_oe !== 2'b11; i++) @(negedge mclk);
		tmo(i);
		dr(12, 32'ha70);
		chk("sample_cap", 32'h5d0, d);
		ir(8'h00);
		for (i = 0; i < 300 && pin_out !== 2'b01; i++) @(negedge mclk);
		tmo(i);
		chk("extest_pins", 32'h7, 32'({pin_out, pin_oe}));
		chk("core_in", 32'ha, 32'(core_in));
		dr(12, 32'ha70);
		chk("extest_cap", 32'h570, d);
		ir(8'hfa);
		dr(2, 32'h3);
		chk("clamp_bypass", 32'h2, d);
		chk("clamp_pins", 32'h7, 32'({pin_out, pin_oe}));
		ir(8'hff);
		@(negedge mclk) in_system_prog = 1'b1;
		for (i = 0; i < 300 && pin_oe !== 2'b00; i++) @(negedge mclk);
		tmo(i);
		chk("isp_oe", 32'h0, 32'({cfg_oe, oer_oe, pin_oe}));
		ir(8'hff);
		chk("isp_cap", 32'h11, 32'(c));
		@(negedge mclk) prog_read_protect = 1'b1;
		@(negedge mclk) prog_read_protect = 1'b0;
		@(negedge mclk) user_code_wr = 1'b1;
		@(negedge mclk) user_code_wr = 1'b0;
		m_u.tap_reset();
		ir(8'hff);
		chk("secure_cap", 32'h19, 32'(c));
		chk("permits", 32'h0, 32'({rd_ok, pg_ok}));
		@(negedge mclk) full_erase_done = 1'b1;
		@(negedge mclk) full_erase_done = 1'b0;
		ir(8'hfd);
		chk("erased_cap", 32'h11, 32'(c));
		dr(32, 32'h0);
		chk("user_code_register", 32'hffffffff, d);
		chk("permits", 32'h3, 32'({rd_ok, pg_ok}));
		tally_and_finish();
	end
endmodule
